// >>> hdl/cmp_ctrl_pkg.sv
// Overview of operation
// - Control-two bit 1 selects the filtered result.
// - Control-two bit 2 connects first input pin.
// - Control-two bit 3 connects second input pin.
// - Control-two bits 7:4 are plain storage.
// - Control-one holds irq flag and enable.
// - Edge select: 0 rising, 1 falling sets flag.
// - Control-one bit 3 powers the comparator.
// - Reference code: off, quarter, half, diode.
// - Control-one bit 6 steers reference path.
// - Reference driven only for nonzero code.
// - Control-one bit 7 swaps comparator inputs.
// - Port buffer disable bits reset to zero.
// - Set bit disables matching port buffer.
//
// Purpose: Constants and carriers for the comparator control block.
// Assumes: AHB-Lite slave, 32-bit data, one word per register.
// Notes:   Register indices are multiplied by four to form byte addresses.
package cmp_ctrl_pkg;

	// ==========================================================
	// Register map.
	localparam logic [7:0] IDX_CTL_FIRST = 8'h59;
	localparam logic [7:0] IDX_CTL_SECOND = 8'h5A;
	localparam logic [7:0] IDX_BUF_OFF = 8'h5B;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h5C;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h5D;
	localparam logic [11:0] ADDR_CTL_FIRST = {2'h0, IDX_CTL_FIRST, 2'h0};
	localparam logic [11:0] ADDR_CTL_SECOND = {2'h0, IDX_CTL_SECOND, 2'h0};
	localparam logic [11:0] ADDR_BUF_OFF = {2'h0, IDX_BUF_OFF, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

	// ==========================================================
	// Control-one field positions.
	localparam int C1_FLAG = 0;
	localparam int C1_ENABLE = 1;
	localparam int C1_EDGE = 2;
	localparam int C1_POWER = 3;
	localparam int C1_REF_LO = 4;
	localparam int C1_REF_HI = 5;
	localparam int C1_PATH = 6;
	localparam int C1_SWAP = 7;

	// Control-two field positions.
	localparam int C2_RESULT = 0;
	localparam int C2_FILTER = 1;
	localparam int C2_PIN_FIRST = 2;
	localparam int C2_PIN_SECOND = 3;
	localparam int C2_SPARE_LO = 4;
	localparam int C2_SPARE_HI = 7;

	// Interrupt status and mask positions.
	localparam int ST_EDGE = 0;
	localparam int ST_CHANGE = 1;

	// ==========================================================
	// Values after reset and timing.
	localparam logic [7:0] RST_CTL_FIRST = 8'h00;
	localparam logic [7:1] RST_CTL_SECOND = 7'h00;
	localparam logic [7:0] RST_BUF_OFF = 8'h00;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [2:0] FILTER_CYCLES = 3'h4;

	// ==========================================================
	// Reference level codes.
	typedef enum logic [1:0] {
		REF_OFF = 2'b00,
		REF_QUARTER = 2'b01,
		REF_HALF = 2'b10,
		REF_DIODE = 2'b11
	} ref_level_e;

	// Settings handed to the analog macro.
	typedef struct packed {
		logic cmp_power_on;
		ref_level_e reference_level_select;
		logic ref_drive;
		logic reference_path_select;
		logic input_swap;
		logic first_pin_connect;
		logic second_pin_connect;
	} analog_ctrl_s;

endpackage

// >>> hdl/comparator_control.sv
// Purpose: Register and control logic around an analog comparator.
// Assumes: AHB-Lite master issues single word transfers only.
// Notes:   Zero wait states; unmapped addresses read zero, OKAY.
`timescale 1ns/1ps
module comparator_control (
	input wire logic i_core_clk, // System clock, 20 MHz.
	input wire logic i_reset_n, // Asynchronous reset, active low.
	input wire logic i_hsel, // Slave select.
	input wire logic [31:0] i_haddr, // Byte address.
	input wire logic [1:0] i_htrans, // Transfer type.
	input wire logic i_hwrite, // High for write.
	input wire logic [2:0] i_hsize, // Transfer size.
	input wire logic [31:0] i_hwdata, // Write data.
	input wire logic i_hready, // Bus ready.
	output logic o_hreadyout, // Slave ready.
	output logic o_hresp, // Response, always OKAY.
	output logic [31:0] o_hrdata, // Read data.
	input wire logic i_cmp_raw, // Raw comparator output.
	output cmp_ctrl_pkg::analog_ctrl_s o_analog, // Analog settings.
	output logic [7:0] o_port_buffer_off, // Port-2 buffer disables.
	output logic o_cmp_result, // Current result.
	output logic o_cmp_irq_req, // Comparator request.
	output logic o_irq // Masked status interrupt.
);
	import cmp_ctrl_pkg::*;

	// ==========================================================
	// Declarations.
	logic dp_valid_q;
	logic dp_write_q;
	logic [11:0] dp_addr_q;
	logic [7:0] ctl_first_q;
	logic [7:1] ctl_second_q;
	logic [7:0] buf_off_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic result_prev_q;
	logic started_q;
	logic filtered;
	logic result_now;
	logic wr_first;
	logic wr_second;
	logic wr_buf;
	logic wr_status;
	logic wr_mask;
	logic rise;
	logic fall;
	logic edge_hit;
	logic any_change;
	logic [7:0] wdata;

	// Decodes one register hit from the latched data phase address.
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// ==========================================================
	// Address phase capture; the slave never inserts wait states.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= 12'h000;
		end else if (i_hready) begin
			dp_valid_q <= i_hsel && i_htrans[1];
			dp_write_q <= i_hwrite;
			dp_addr_q <= i_haddr[11:0];
		end
	end

	// Upper address bits are not decoded; the block aliases in its slot.
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign wdata = i_hwdata[7:0];

	// Write strobes, valid in the data phase.
	assign wr_first = dp_valid_q && dp_write_q &&
		hit(dp_addr_q, ADDR_CTL_FIRST);
	assign wr_second = dp_valid_q && dp_write_q &&
		hit(dp_addr_q, ADDR_CTL_SECOND);
	assign wr_buf = dp_valid_q && dp_write_q &&
		hit(dp_addr_q, ADDR_BUF_OFF);
	assign wr_status = dp_valid_q && dp_write_q &&
		hit(dp_addr_q, ADDR_IRQ_STATUS);
	assign wr_mask = dp_valid_q && dp_write_q &&
		hit(dp_addr_q, ADDR_IRQ_MASK);

	// ==========================================================
	// Result path.
	result_filter u_filter (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_raw(i_cmp_raw),
		.i_filter_en(ctl_second_q[C2_FILTER]),
		.o_result(filtered)
	);

	// A powered-down comparator reports low rather than a stale level.
	assign result_now = ctl_first_q[C1_POWER] && filtered;
	assign o_cmp_result = result_now;

	// Previous result for edge detection.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			result_prev_q <= 1'b0;
		end else begin
			result_prev_q <= result_now;
		end
	end

	assign rise = result_now && !result_prev_q;
	assign fall = !result_now && result_prev_q;
	assign edge_hit = ctl_first_q[C1_EDGE] ? fall : rise;
	assign any_change = rise || fall;

	// ==========================================================
	// Control-one: the flag is set by hardware; a set beats a clear.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_first_q <= RST_CTL_FIRST;
		end else begin
			if (wr_first) begin
				ctl_first_q[7:1] <= wdata[7:1];
			end
			if (edge_hit) begin
				ctl_first_q[C1_FLAG] <= 1'b1;
			end else if (wr_first) begin
				ctl_first_q[C1_FLAG] <= wdata[C1_FLAG];
			end
		end
	end

	// Control-two: bit 0 is not stored, it reads the live result.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_second_q <= RST_CTL_SECOND;
		end else if (wr_second) begin
			ctl_second_q <= wdata[7:1];
		end
	end

	// Port-2 input buffer disables.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			buf_off_q <= RST_BUF_OFF;
		end else if (wr_buf) begin
			buf_off_q <= wdata;
		end
	end

	// ==========================================================
	// Sticky status, write one to clear; a new event beats the clear.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status_q <= RST_IRQ;
		end else begin
			irq_status_q[ST_EDGE] <= edge_hit ||
				(irq_status_q[ST_EDGE] && !(wr_status && wdata[ST_EDGE]));
			irq_status_q[ST_CHANGE] <= any_change ||
				(irq_status_q[ST_CHANGE] &&
				!(wr_status && wdata[ST_CHANGE]));
		end
	end

	// Interrupt mask.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_mask_q <= RST_IRQ;
		end else if (wr_mask) begin
			irq_mask_q <= wdata[1:0];
		end
	end

	assign o_irq = |(irq_status_q & irq_mask_q);
	assign o_cmp_irq_req = ctl_first_q[C1_FLAG] &&
		ctl_first_q[C1_ENABLE];

	// ==========================================================
	// Read data in the data phase, built from register contents.
	always_comb begin
		o_hrdata = 32'h0000_0000;
		if (dp_valid_q && !dp_write_q) begin
			case (dp_addr_q)
				ADDR_CTL_FIRST: begin
					o_hrdata[7:0] = ctl_first_q;
				end
				ADDR_CTL_SECOND: begin
					o_hrdata[7:0] = {ctl_second_q, result_now};
				end
				ADDR_BUF_OFF: begin
					o_hrdata[7:0] = buf_off_q;
				end
				ADDR_IRQ_STATUS: begin
					o_hrdata[1:0] = irq_status_q;
				end
				ADDR_IRQ_MASK: begin
					o_hrdata[1:0] = irq_mask_q;
				end
				default: begin
					o_hrdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ==========================================================
	// Analog settings. Spare control-two bits reach nothing.
	assign o_analog.cmp_power_on = ctl_first_q[C1_POWER];
	assign o_analog.reference_level_select =
		ref_level_e'(ctl_first_q[C1_REF_HI:C1_REF_LO]);
	assign o_analog.ref_drive =
		(ctl_first_q[C1_REF_HI:C1_REF_LO] != REF_OFF);
	assign o_analog.reference_path_select = ctl_first_q[C1_PATH];
	assign o_analog.input_swap = ctl_first_q[C1_SWAP];
	assign o_analog.first_pin_connect =
		ctl_second_q[C2_PIN_FIRST];
	assign o_analog.second_pin_connect =
		ctl_second_q[C2_PIN_SECOND];
	assign o_port_buffer_off = buf_off_q;

	// ==========================================================
	// Checks. The helper marks the first cycle after reset release.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_filter_select: assert property (
		wr_second |=> u_filter.i_filter_en == $past(wdata[C2_FILTER]))
		else $error("Filter select not taken from write.");
	a_first_pin: assert property (
		wr_second |=> o_analog.first_pin_connect ==
		$past(wdata[C2_PIN_FIRST]))
		else $error("First pin connect does not follow write.");
	a_second_pin: assert property (
		wr_second |=> o_analog.second_pin_connect ==
		$past(wdata[C2_PIN_SECOND]))
		else $error("Second pin connect does not follow write.");
	a_spare_store: assert property (
		wr_second |=> ctl_second_q[C2_SPARE_HI:C2_SPARE_LO] ==
		$past(wdata[C2_SPARE_HI:C2_SPARE_LO]))
		else $error("Spare bits not stored.");
	a_enable_store: assert property (
		wr_first |=> ctl_first_q[C1_ENABLE] == $past(wdata[C1_ENABLE]))
		else $error("Interrupt enable not stored.");
	a_edge_sets_flag: assert property (
		(ctl_first_q[C1_EDGE] ? fall : rise) |=> ctl_first_q[C1_FLAG])
		else $error("Selected edge did not set the flag.");
	a_power_gate: assert property (
		!o_analog.cmp_power_on |-> !o_cmp_result)
		else $error("Result high while comparator off.");
	a_ref_level: assert property (
		wr_first |=> o_analog.reference_level_select ==
		$past(wdata[C1_REF_HI:C1_REF_LO]))
		else $error("Reference code does not follow write.");
	a_ref_path: assert property (
		wr_first |=> o_analog.reference_path_select ==
		$past(wdata[C1_PATH]))
		else $error("Reference path does not follow write.");
	a_ref_drive: assert property (
		o_analog.ref_drive ==
		(o_analog.reference_level_select != REF_OFF))
		else $error("Reference drive mismatches its code.");
	a_input_swap: assert property (
		wr_first |=> o_analog.input_swap == $past(wdata[C1_SWAP]))
		else $error("Input swap does not follow write.");
	a_bufoff_reset: assert property (
		!started_q |-> o_port_buffer_off == 8'h00)
		else $error("Buffer disables not clear after reset.");
	a_bufoff_write: assert property (
		wr_buf |=> o_port_buffer_off == $past(wdata))
		else $error("Buffer disables do not follow write.");
	a_result_read: assert property (
		dp_valid_q && !dp_write_q && hit(dp_addr_q, ADDR_CTL_SECOND)
		|-> o_hrdata[C2_RESULT] == result_now)
		else $error("Read of result bit is wrong.");
	a_flag_sticky: assert property (
		ctl_first_q[C1_FLAG] && !(wr_first && !wdata[C1_FLAG])
		|=> ctl_first_q[C1_FLAG])
		else $error("Flag dropped without a zero write.");
	a_irq_request: assert property (
		o_cmp_irq_req == (ctl_first_q[C1_FLAG] && ctl_first_q[C1_ENABLE]))
		else $error("Request mismatches flag and enable.");

	// Flag handling: a zero write clears, an edge in the same cycle wins,
	// and the edge that is not selected leaves a clear flag alone.
	a_flag_clear: assert property (
		wr_first && !wdata[C1_FLAG] && !edge_hit
		|=> !ctl_first_q[C1_FLAG])
		else $error("Zero write did not clear the flag.");
	a_flag_set_wins: assert property (
		edge_hit && wr_first && !wdata[C1_FLAG] |=> ctl_first_q[C1_FLAG])
		else $error("Clear beat a simultaneous edge.");
	a_other_edge: assert property (
		!ctl_first_q[C1_FLAG] && !wr_first &&
		(ctl_first_q[C1_EDGE] ? rise : fall)
		|=> !ctl_first_q[C1_FLAG])
		else $error("Unselected edge set the flag.");

	// Sticky status bits hold until a one is written, and the mask gates.
	a_status_sticky: assert property (
		irq_status_q[ST_EDGE] && !(wr_status && wdata[ST_EDGE])
		|=> irq_status_q[ST_EDGE])
		else $error("Edge status dropped without a one write.");
	a_status_clear: assert property (
		wr_status && wdata[ST_CHANGE] && !any_change
		|=> !irq_status_q[ST_CHANGE])
		else $error("One write did not clear change status.");
	a_change_status: assert property (
		any_change |=> irq_status_q[ST_CHANGE])
		else $error("Result change not recorded in status.");
	a_irq_masked: assert property (
		irq_mask_q == 2'h0 |-> !o_irq)
		else $error("Interrupt raised with every source masked.");

	// Bus side and the remaining control-one fields.
	a_bus_okay: assert property (
		o_hreadyout && !o_hresp)
		else $error("Slave stalled or answered with an error.");
	a_rdata_idle: assert property (
		!(dp_valid_q && !dp_write_q) |-> o_hrdata == 32'h0000_0000)
		else $error("Read data not zero outside a read.");
	a_ref_drive_write: assert property (
		wr_first |=> o_analog.ref_drive ==
		($past(wdata[C1_REF_HI:C1_REF_LO]) != 2'b00))
		else $error("Reference drive does not follow written code.");
	a_power_follow: assert property (
		wr_first |=> o_analog.cmp_power_on == $past(wdata[C1_POWER]))
		else $error("Power control does not follow write.");

	c_rising_flag: cover property (
		!ctl_first_q[C1_EDGE] && rise ##1 ctl_first_q[C1_FLAG]);
	c_falling_flag: cover property (
		ctl_first_q[C1_EDGE] && fall ##1 ctl_first_q[C1_FLAG]);
	c_flag_cleared: cover property (
		ctl_first_q[C1_FLAG] ##1 !ctl_first_q[C1_FLAG]);
	c_irq_level: cover property (o_irq && o_cmp_irq_req);
	c_swap_rise: cover property (o_analog.input_swap && rise);
endmodule

// >>> hdl/result_filter.sv
// Purpose: Synchronise the raw comparator output and optionally filter it.
// Assumes: Raw output is asynchronous to i_core_clk.
// Notes:   A level counts once the second and third stages agree.
`timescale 1ns/1ps
module result_filter (
	input wire logic i_core_clk, // System clock.
	input wire logic i_reset_n, // Asynchronous reset, active low.
	input wire logic i_raw, // Raw comparator output.
	input wire logic i_filter_en, // High selects the filter.
	output logic o_result // Synchronised result.
);
	import cmp_ctrl_pkg::*;

	logic [2:0] sync_q;
	logic [2:0] cnt_q;
	logic result_q;
	logic agree;
	logic level;

	// ==========================================================
	// Three stage synchroniser; stage zero feeds only stage one.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], i_raw};
		end
	end

	assign agree = (sync_q[1] == sync_q[2]);
	assign level = sync_q[2];

	// Counts agreed samples that differ from the held result.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 3'h0;
		end else if (!agree || level == result_q) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != FILTER_CYCLES) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	// The filter trades a few cycles of delay for glitch immunity.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			result_q <= 1'b0;
		end else if (agree && level != result_q) begin
			if (!i_filter_en || cnt_q == FILTER_CYCLES - 3'h1) begin
				result_q <= level;
			end
		end
	end

	assign o_result = result_q;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	a_filter_bypass: assert property (
		!i_filter_en && agree && level != result_q |=> result_q == $past(level))
		else $error("Unfiltered result did not follow agreed level.");
	a_filter_hold: assert property (
		i_filter_en && $changed(result_q) |-> $past(cnt_q) == FILTER_CYCLES - 3'h1)
		else $error("Filtered result changed before count completed.");
endmodule

// >>> verification/cmp_analog_model.sv
// Purpose: Behavioural analog comparator at the far side of the block.
// Assumes: The bench gives the pin-side level as a single bit.
// Notes:   While unpowered the output wanders, as a real one would.
`timescale 1ns/1ps
module cmp_analog_model
	import cmp_ctrl_pkg::*;
(
	input wire logic i_core_clk, // Paces the wander pattern.
	input wire cmp_ctrl_pkg::analog_ctrl_s i_analog, // Block settings.
	input wire logic i_level, // High when the input exceeds reference.
	output logic o_raw // Raw comparator output.
);
	logic wander_q = 1'b0;

	// ==========================================================
	// An unpowered comparator has no defined output, so it toggles.
	always_ff @(posedge i_core_clk) begin
		wander_q <= ~wander_q;
	end

	// Exchanging the inputs inverts the sense of the comparison.
	assign o_raw = i_analog.cmp_power_on ? (i_level ^ i_analog.input_swap) :
		wander_q;
endmodule

// >>> verification/tb_comparator_control.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Zero wait state slave; bench is the only bus master.
// Notes:   A register model is compared with every read and output.
`timescale 1ns/1ps
module tb_comparator_control;
	import cmp_ctrl_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, raw, result, irq_req, irq, level = 1'b0;
	analog_ctrl_s analog;
	logic [7:0] buf_off;
	logic [7:0] m_c1 = 8'h00;
	logic [7:1] m_c2 = 7'h00;
	logic [7:0] m_buf = 8'h00;
	logic [1:0] m_st = 2'h0;
	logic [1:0] m_mk = 2'h0;
	logic m_res = 1'b0;
	logic [15:0] seed = 16'h3323;
	logic [11:0] addrs [6] = '{ADDR_CTL_FIRST, ADDR_CTL_SECOND,
		ADDR_BUF_OFF, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 12'h180};
	int num_errors = 0;
	int num_checks = 0;

	// ==========================================================
	// Clock, design and far-side model.
	always #25 core_clk = ~core_clk;

	comparator_control i_dut (.i_core_clk(core_clk), .i_reset_n(reset_n),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_cmp_raw(raw), .o_analog(analog),
		.o_port_buffer_off(buf_off), .o_cmp_result(result),
		.o_cmp_irq_req(irq_req), .o_irq(irq));

	cmp_analog_model i_far (.i_core_clk(core_clk), .i_analog(analog),
		.i_level(level), .o_raw(raw));

	// ==========================================================
	// Helpers.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	function automatic logic [31:0] expect_of(input logic [11:0] a);
		case (a)
			ADDR_CTL_FIRST: return {24'h0, m_c1};
			ADDR_CTL_SECOND: return {24'h0, m_c2, m_res};
			ADDR_BUF_OFF: return {24'h0, m_buf};
			ADDR_IRQ_STATUS: return {30'h0, m_st};
			ADDR_IRQ_MASK: return {30'h0, m_mk};
			default: return 32'h0;
		endcase
	endfunction

	// One single transfer; entered just after a rising edge. Only the
	// watchdog ends a wait for ready, so a stuck slave is still a failure.
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do begin
			@(posedge core_clk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do begin
			@(posedge core_clk);
		end while (hreadyout !== 1'b1);
		r = hrdata;
		check(32'(hresp), 32'h0);
	endtask

	// Writes keep the model in step; status bits clear on a written one.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		case (a)
			ADDR_CTL_FIRST: m_c1 = d[7:0];
			ADDR_CTL_SECOND: m_c2 = d[7:1];
			ADDR_BUF_OFF: m_buf = d[7:0];
			ADDR_IRQ_STATUS: m_st = m_st & ~d[1:0];
			ADDR_IRQ_MASK: m_mk = d[1:0];
			default: ;
		endcase
	endtask

	task automatic rd(input logic [11:0] a);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, expect_of(a));
	endtask

	// Outputs are looked at mid-cycle, where they have settled.
	task automatic chk_out();
		@(negedge core_clk);
		check(32'(analog), {24'h0, m_c1[3], m_c1[5:4], m_c1[5:4] != 2'h0,
			m_c1[6], m_c1[7], m_c2[2], m_c2[3]});
		check(32'(buf_off), {24'h0, m_buf});
		check(32'(result), {31'h0, m_res});
		check(32'(irq_req), {31'h0, m_c1[0] & m_c1[1]});
		check(32'(irq), {31'h0, |(m_st & m_mk)});
		@(posedge core_clk);
	endtask

	// Waits for the result the model predicts, then books its events.
	task automatic settle();
		logic e;
		int n;
		@(posedge core_clk);
		e = m_c1[3] & (level ^ m_c1[7]);
		if (e != m_res) begin
			n = 0;
			while (result !== e && n < 30) begin
				@(posedge core_clk);
				n++;
			end
			check(32'(result), {31'h0, e});
			repeat (2) @(posedge core_clk);
			m_st[1] = 1'b1;
			if (e != m_c1[2]) begin
				m_c1[0] = 1'b1;
				m_st[0] = 1'b1;
			end
			m_res = e;
		end
		chk_out();
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			rd(addrs[i]);
		end
		chk_out();
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(ADDR_BUF_OFF, {24'h0, seed[7:0]});
			rd(ADDR_BUF_OFF);
			wr(ADDR_CTL_SECOND, {24'h0, seed[15:10], 1'b0, seed[8]});
			rd(ADDR_CTL_SECOND);
			chk_out();
		end
		wr(ADDR_IRQ_MASK, 32'h3);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CTL_FIRST, {24'h0, 1'b0, k[0], k[1:0], 4'hA});
			settle();
		end
		level <= 1'b1;
		settle();
		rd(ADDR_CTL_FIRST);
		rd(ADDR_IRQ_STATUS);
		rd(ADDR_CTL_SECOND);
		wr(ADDR_CTL_FIRST, {24'h0, m_c1 & 8'hFE});
		settle();
		level <= 1'b0;
		settle();
		wr(ADDR_IRQ_STATUS, 32'h3);
		wr(ADDR_CTL_FIRST, {24'h0, m_c1 | 8'h04});
		level <= 1'b1;
		settle();
		level <= 1'b0;
		settle();
		rd(ADDR_CTL_FIRST);
		wr(ADDR_CTL_FIRST, {24'h0, m_c1 | 8'h80});
		settle();
		wr(ADDR_CTL_FIRST, {24'h0, m_c1 & 8'h77});
		settle();
		// Power returns with the input high, so the held low result rises.
		level <= 1'b1;
		wr(ADDR_CTL_FIRST, {24'h0, m_c1 | 8'h08});
		wr(ADDR_CTL_SECOND, {24'h0, m_c2[7:2], 2'b10});
		settle();
		// A three-cycle dip would pass unfiltered but not the filter.
		level <= 1'b0;
		repeat (3) @(posedge core_clk);
		level <= 1'b1;
		repeat (12) begin
			@(negedge core_clk);
			check(32'(result), {31'h0, m_res});
		end
		@(posedge core_clk);
		level <= 1'b0;
		settle();
		wr(ADDR_IRQ_MASK, 32'h0);
		settle();
		wr(ADDR_IRQ_STATUS, 32'h3);
		rd(ADDR_IRQ_STATUS);
		tally_and_finish();
	end

	// The run takes about two hundred cycles; the watchdog allows twenty times that.
	initial begin
		repeat (4000) @(posedge core_clk);
		num_errors++;
		tally_and_finish();
	end
endmodule
